// ===== src/psc_map.svh
// Constants of the pressure sensor command block.
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
`define PSC_CMD_NOOP 8'h00
`define PSC_CMD_REBOOT 8'h01
`define PSC_CMD_START 8'h04
`define PSC_CMD_HALT 8'h05
`define PSC_CMD_FETCH_SAMPLE 8'h06
`define PSC_CMD_FETCH_BARO 8'h07
`define PSC_CMD_FETCH_ID 8'h0C
`define PSC_ST_ONE_BIT 0
`define PSC_ST_COMP_BIT 1
`define PSC_ST_REPEAT_BIT 2
`define PSC_ST_MEAS_BIT 3
`define PSC_ST_SAMPLE_BIT 4
`define PSC_ST_BARO_BIT 5
`define PSC_ST_ZERO_BIT 6
`define PSC_ST_SEVEN_BIT 7
`define PSC_BARO_EVERY 2'd3
`define PSC_FIRST_MEASURING_FLAG_MS 15
`define PSC_NEXT_MEASURING_FLAG_MS 4
`define PSC_CLK_MHZ 100
`define PSC_ID_RSV_FIRST 6'd31
`define PSC_ID_FILL 8'hFF
`endif

// ===== src/psc_pkg.sv
// Types of the pressure sensor command block.
package psc_pkg;
    typedef enum logic [1:0] {
        PSC_IDLE = 2'b00,
        PSC_MEASURING_FLAG = 2'b01,
        PSC_DONE = 2'b11
    } psc_measuring_flag_e;
    typedef struct packed {
        logic signed [23:0] pressure;
        logic signed [15:0] temperature;
        logic signed [15:0] supply;
    } psc_sample_s;
    typedef struct packed {
        logic [31:0] cm_pressure;
        logic signed [15:0] baro_temp;
    } psc_baro_s;
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] param;
        logic has_param;
    } psc_cmd_s;
endpackage

// ===== src/psc_sensor.sv
// Command layer of the differential pressure sensor behind its serial port.
// Functional notes
// - In repeat mode every third conversion also yields a barometer result, sets bit 5.
// - Barometer fetch command clears the fresh barometer flag.
// - Status bit 6 reads zero and bit 7 reads one.
// - No-op command changes nothing and only returns status.
// - Reboot command resets the sensor state except the held sample and barometer result copies.
// - Start command takes exactly one parameter byte; host sets its bit 0.
// - Parameter bit 1 selects common-mode correction of the output.
// - Parameter bit 2 selects single shot or repeated conversions.
// - Halt command ends repeat mode; running conversion still completes.
// - Sample fetch returns 8 bytes: dummy, pressure, temperature, supply, LSB first.
// - Pressure is signed 24 bits in pascal times 256.
// - Temperature and supply are signed 16-bit corrected values.
// - Barometer fetch returns 4 pressure bytes then 2 temperature bytes, LSB first.
// - Common-mode pressure is unsigned 32 bits in pascals.
// - Barometer temperature is signed 16 bits in hundredths of a degree.
// - Identity command returns a 64-byte stored record.
// - Identity bytes 0-1 are firmware minor and major, bytes 2-12 part number.
// - Identity bytes 31 to 63 read as 0xFF.
// - First conversion takes about 15 ms, following ones about 4 ms.
// - Each new result sets fresh sample flag and ready; sample fetch clears it.
// - Measuring flag set on start, cleared when the last conversion ends.
// - Serial link is mode 1: change on rising edge, sample on falling edge.
// - Every packet returns the status byte while the command byte arrives.
`include "psc_map.svh"
module psc_sensor #(
    parameter int unsigned FIRST_MEASURING_FLAG_CYC = `PSC_FIRST_MEASURING_FLAG_MS * `PSC_CLK_MHZ * 1000,
    parameter int unsigned NEXT_MEASURING_FLAG_CYC = `PSC_NEXT_MEASURING_FLAG_MS * `PSC_CLK_MHZ * 1000,
    parameter logic [7:0] FW_MINOR = 8'h01,
    parameter logic [7:0] FW_MAJOR = 8'h01,
    parameter logic [87:0] PART_NUMBER = 88'h4142_4344_4546_4748_494A_4B,
    parameter logic [143:0] ID_MIDDLE = 144'h0
) (
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    input wire logic SCLK_I,
    input wire logic CS_N_I,
    input wire logic MOSI_I,
    input wire psc_pkg::psc_sample_s SAMPLE_I,
    input wire psc_pkg::psc_baro_s BARO_I,
    output logic MISO_O,
    output logic READY_O,
    output logic [7:0] STATUS_O
);
    import psc_pkg::*;

    // Link domain: bit shifting on the serial clock. Reset when select is high.
    logic link_rst;
    logic [2:0] bit_cnt_ff;
    logic [6:0] rx_sh_ff;
    logic [5:0] byte_idx_ff;
    logic [7:0] cmd_ff;
    logic [7:0] tx_sh_ff;
    logic got_cmd_tgl_ff;
    logic got_par_tgl_ff;
    logic [7:0] par_ff;
    logic miso_ff;
    assign link_rst = RESET_I | CS_N_I;
    wire [7:0] rx_byte = {rx_sh_ff, MOSI_I};
    wire byte_end = (bit_cnt_ff == 3'd7);

    // Status snapshot for the link: the status bits only move between packets in practice,
    // so the link reads the core-clock register copy directly; nothing holds it while select is low.
    logic [7:0] status_ff;

    function automatic logic [7:0] id_byte(input logic [5:0] i);
        if (i >= `PSC_ID_RSV_FIRST) return `PSC_ID_FILL;
        else if (i == 6'd0) return FW_MINOR;
        else if (i == 6'd1) return FW_MAJOR;
        else if (i <= 6'd12) return PART_NUMBER[8*(12-i) +: 8];
        else return ID_MIDDLE[8*(30-i) +: 8];
    endfunction

    logic [63:0] samp_shadow_ff;
    logic [47:0] baro_shadow_ff;
    function automatic logic [7:0] pay_byte(input logic [7:0] c, input logic [5:0] i);
        case (c)
            `PSC_CMD_FETCH_SAMPLE: pay_byte = (i < 6'd8) ? samp_shadow_ff[8*i[2:0] +: 8]
                : 8'h00;
            `PSC_CMD_FETCH_BARO: pay_byte = (i < 6'd6) ? baro_shadow_ff[8*i[2:0] +: 8]
                : 8'h00;
            `PSC_CMD_FETCH_ID: pay_byte = id_byte(i);
            default: pay_byte = 8'h00;
        endcase
    endfunction

    // Data are sampled on the falling edge, driven on the rising edge (mode 1).
    always_ff @(negedge SCLK_I or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt_ff <= 3'd0;
            rx_sh_ff <= 7'h00;
            byte_idx_ff <= 6'd0;
            cmd_ff <= 8'h00;
            par_ff <= 8'h00;
        end else begin
            bit_cnt_ff <= bit_cnt_ff + 3'd1;
            rx_sh_ff <= rx_byte[6:0];
            if (byte_end) begin
                if (byte_idx_ff == 6'd0) cmd_ff <= rx_byte;
                if (byte_idx_ff == 6'd1) par_ff <= rx_byte;
                if (byte_idx_ff != 6'd63) byte_idx_ff <= byte_idx_ff + 6'd1;
            end
        end
    end

    // Event toggles survive the select reset so the core sees every command.
    always_ff @(negedge SCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            got_cmd_tgl_ff <= 1'b0;
            got_par_tgl_ff <= 1'b0;
        end else if (!CS_N_I && byte_end) begin
            if (byte_idx_ff == 6'd0 && rx_byte != `PSC_CMD_START) got_cmd_tgl_ff <= ~got_cmd_tgl_ff;
            if (byte_idx_ff == 6'd1 && cmd_ff == `PSC_CMD_START) got_par_tgl_ff <= ~got_par_tgl_ff;
        end
    end
    logic [7:0] lcmd_ff;
    always_ff @(negedge SCLK_I or posedge RESET_I) begin
        if (RESET_I) lcmd_ff <= 8'h00;
        else if (!CS_N_I && byte_end && byte_idx_ff == 6'd0) lcmd_ff <= rx_byte;
    end

    // Transmit: status first, then payload bytes in ascending order.
    wire [5:0] pay_idx = byte_idx_ff - 6'd1;
    always_ff @(posedge SCLK_I or posedge link_rst) begin
        if (link_rst) begin
            tx_sh_ff <= 8'h00;
            miso_ff <= 1'b0;
        end else if (bit_cnt_ff == 3'd0) begin
            if (byte_idx_ff == 6'd0) begin
                miso_ff <= status_ff[7];
                tx_sh_ff <= {status_ff[6:0], 1'b0};
            end else begin
                miso_ff <= pay_byte(cmd_ff, pay_idx)[7];
                tx_sh_ff <= {pay_byte(cmd_ff, pay_idx)[6:0], 1'b0};
            end
        end else begin
            miso_ff <= tx_sh_ff[7];
            tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
        end
    end
    assign MISO_O = miso_ff;

    // Crossing into the core domain: only the event toggles pass through two flops.
    logic [1:0] cmd_sync_ff;
    logic [1:0] par_sync_ff;
    logic cmd_seen_ff;
    logic par_seen_ff;
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            cmd_sync_ff <= 2'b00;
            par_sync_ff <= 2'b00;
            cmd_seen_ff <= 1'b0;
            par_seen_ff <= 1'b0;
        end else begin
            cmd_sync_ff <= {cmd_sync_ff[0], got_cmd_tgl_ff};
            par_sync_ff <= {par_sync_ff[0], got_par_tgl_ff};
            cmd_seen_ff <= cmd_sync_ff[1];
            par_seen_ff <= par_sync_ff[1];
        end
    end
    // The command and parameter bytes are written on the same serial edge as their toggle, so they are stable when it arrives.
    wire cmd_evt = cmd_sync_ff[1] ^ cmd_seen_ff;
    wire par_evt = par_sync_ff[1] ^ par_seen_ff;
    wire is_reboot = cmd_evt && (lcmd_ff == `PSC_CMD_REBOOT);
    wire is_halt = cmd_evt && (lcmd_ff == `PSC_CMD_HALT);
    wire is_fetch_s = cmd_evt && (lcmd_ff == `PSC_CMD_FETCH_SAMPLE);
    wire is_fetch_b = cmd_evt && (lcmd_ff == `PSC_CMD_FETCH_BARO);
    wire is_start = par_evt;

    // Core conversion engine.
    psc_measuring_flag_e state_ff;
    logic [31:0] tmr_ff;
    logic first_ff;
    logic comp_ff;
    logic repeat_ff;
    logic [1:0] baro_cnt_ff;
    logic fresh_sample_flag_ff;
    logic fresh_baro_flag_ff;
    logic measuring_flag_ff;
    logic ready_ff;
    wire measuring_flag_done = (state_ff == PSC_MEASURING_FLAG) && (tmr_ff == 32'd0);
    wire baro_due = measuring_flag_done && repeat_ff && (baro_cnt_ff == `PSC_BARO_EVERY - 2'd1);

    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_ff <= PSC_IDLE;
            tmr_ff <= 32'd0;
            first_ff <= 1'b1;
            comp_ff <= 1'b1;
            repeat_ff <= 1'b0;
            baro_cnt_ff <= 2'd0;
            fresh_sample_flag_ff <= 1'b0;
            fresh_baro_flag_ff <= 1'b0;
            measuring_flag_ff <= 1'b0;
            ready_ff <= 1'b0;
            samp_shadow_ff <= 64'h0;
            baro_shadow_ff <= 48'h0;
        end else if (is_reboot) begin
            state_ff <= PSC_IDLE;
            tmr_ff <= 32'd0;
            first_ff <= 1'b1;
            comp_ff <= 1'b1;
            repeat_ff <= 1'b0;
            baro_cnt_ff <= 2'd0;
            fresh_sample_flag_ff <= 1'b0;
            fresh_baro_flag_ff <= 1'b0;
            measuring_flag_ff <= 1'b0;
            ready_ff <= 1'b0;
        end else begin
            // A no-op command matches none of the decodes and changes nothing.
            case (state_ff)
                PSC_IDLE: begin
                    if (is_start) begin
                        state_ff <= PSC_MEASURING_FLAG;
                        measuring_flag_ff <= 1'b1;
                        comp_ff <= par_ff[1];
                        repeat_ff <= par_ff[2];
                        baro_cnt_ff <= 2'd0;
                        tmr_ff <= first_ff ? FIRST_MEASURING_FLAG_CYC - 1 : NEXT_MEASURING_FLAG_CYC - 1;
                        first_ff <= 1'b0;
                    end
                end
                PSC_MEASURING_FLAG: begin
                    if (is_halt) repeat_ff <= 1'b0;
                    if (tmr_ff != 32'd0) tmr_ff <= tmr_ff - 32'd1;
                    else begin
                        samp_shadow_ff <= {SAMPLE_I.supply, SAMPLE_I.temperature,
                            SAMPLE_I.pressure, 8'h00};
                        if (repeat_ff && !is_halt) begin
                            tmr_ff <= NEXT_MEASURING_FLAG_CYC - 1;
                            baro_cnt_ff <= baro_due ? 2'd0 : baro_cnt_ff + 2'd1;
                        end else begin
                            state_ff <= PSC_DONE;
                        end
                    end
                end
                PSC_DONE: begin
                    measuring_flag_ff <= 1'b0;
                    state_ff <= PSC_IDLE;
                end
                default: state_ff <= PSC_IDLE;
            endcase
            if (baro_due)
                baro_shadow_ff <= {BARO_I.baro_temp, BARO_I.cm_pressure};
            // Setting wins over the fetch that clears in the same cycle.
            if (baro_due) fresh_baro_flag_ff <= 1'b1;
            else if (is_fetch_b) fresh_baro_flag_ff <= 1'b0;
            if (measuring_flag_done) fresh_sample_flag_ff <= 1'b1;
            else if (is_fetch_s) fresh_sample_flag_ff <= 1'b0;
            if (measuring_flag_done) ready_ff <= 1'b1;
            else if (is_fetch_s || is_start) ready_ff <= 1'b0;
        end
    end

    wire [7:0] nxt_status = {1'b1, 1'b0, fresh_baro_flag_ff, fresh_sample_flag_ff,
        measuring_flag_ff, repeat_ff, comp_ff, 1'b1};
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) status_ff <= 8'h83;
        else status_ff <= nxt_status;
    end
    assign STATUS_O = status_ff;
    assign READY_O = ready_ff;
endmodule // psc_sensor

// ===== bench/psc_sensor_props.sv
// Concurrent checks on the ports of the pressure sensor command block.
module psc_sensor_props (
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    input wire logic CS_N_I,
    input wire logic MISO_O,
    input wire logic READY_O,
    input wire logic [7:0] STATUS_O
);
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RESET_I);
    property p_fixed_bits;
        STATUS_O[7] && !STATUS_O[6] && STATUS_O[0];
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("Status fixed bits wrong.");
    property p_reset_status;
        $fell(RESET_I) |-> STATUS_O == 8'h83 && !READY_O;
    endproperty
    a_reset_status: assert property (p_reset_status) else $error("Reset state wrong.");
    property p_ready_sample;
        $rose(READY_O) |-> ##[0:2] STATUS_O[4];
    endproperty
    a_ready_sample: assert property (p_ready_sample) else $error("Ready without flag.");
    // A reboot also clears the flags, so its status value is left out here.
    property p_fetch_drops;
        $fell(STATUS_O[4]) && STATUS_O != 8'h83 |-> ##[0:2] !READY_O;
    endproperty
    a_fetch_drops: assert property (p_fetch_drops) else $error("Ready kept after fetch.");
    property p_start_drops;
        $rose(STATUS_O[3]) |-> ##[0:2] !READY_O;
    endproperty
    a_start_drops: assert property (p_start_drops) else $error("Ready kept at start.");
    property p_meas_end;
        $fell(STATUS_O[3]) && STATUS_O != 8'h83 |-> ##[0:2] (STATUS_O[4] && READY_O);
    endproperty
    a_meas_end: assert property (p_meas_end) else $error("Conversion end without result.");
    property p_baro_sample;
        $rose(STATUS_O[5]) |-> ##[0:2] (STATUS_O[4] && READY_O);
    endproperty
    a_baro_sample: assert property (p_baro_sample) else $error("Barometer flag alone.");
    property p_miso_idle;
        CS_N_I [*3] |-> !MISO_O;
    endproperty
    a_miso_idle: assert property (p_miso_idle) else $error("Serial out busy while idle.");
endmodule // psc_sensor_props
bind psc_sensor psc_sensor_props u_props (.CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I),
    .CS_N_I(CS_N_I), .MISO_O(MISO_O), .READY_O(READY_O), .STATUS_O(STATUS_O));

// ===== bench/psc_host_model.sv
// Serial bus master model standing in for the host controller.
module psc_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rx_q[$];
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // The gap after each byte gives the core time to take in the byte's event toggle before the next byte or select rising.
    task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk_o = 1'b1;
            mosi_o = tx[i];
            #7.5;
            sclk_o = 1'b0;
            rx[i] = miso_i;
            #7.5;
        end
        mosi_o = ~mosi_o;
        #300;
    endtask
    task automatic packet(input logic [7:0] cmd, input logic [7:0] param, input bit has_param,
                          input int n_read);
        logic [7:0] b;
        rx_q = {};
        cs_n_o = 1'b0;
        #300;
        xfer_byte(cmd, b);
        rx_q.push_back(b);
        if (has_param) begin
            xfer_byte(param | 8'h01, b);
        end
        for (int k = 0; k < n_read; k++) begin
            xfer_byte(8'h00, b);
            rx_q.push_back(b);
        end
        cs_n_o = 1'b1;
        #1000;
    endtask
endmodule // psc_host_model

// ===== bench/psc_sensor_bench.sv
// Self-checking bench of the pressure sensor command block.
`include "psc_map.svh"
module psc_sensor_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import psc_pkg::*;
    localparam int FIRST_CYC = 2000;
    localparam int NEXT_CYC = 1000;
    localparam logic [7:0] FW_MIN = 8'h12; // Arbitrary value.
    localparam logic [7:0] FW_MAJ = 8'h34; // Arbitrary value.
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sclk, cs_n, mosi, miso, ready;
    logic [7:0] status;
    psc_sample_s sample = '{24'hF1_2345, 16'h0A0B, 16'h0C0D};
    psc_baro_s baro = '{32'h0001_86A0, 16'h09C4};
    int err_total = 0;
    int compares = 0;
    int cyc;
    always #5 clk = ~clk;
    psc_sensor #(.FIRST_MEASURING_FLAG_CYC(FIRST_CYC), .NEXT_MEASURING_FLAG_CYC(NEXT_CYC), .FW_MINOR(FW_MIN),
        .FW_MAJOR(FW_MAJ)) u_dut (.CORE_CLK_I(clk), .RESET_I(rst), .SCLK_I(sclk),
        .CS_N_I(cs_n), .MOSI_I(mosi), .SAMPLE_I(sample), .BARO_I(baro), .MISO_O(miso),
        .READY_O(ready), .STATUS_O(status));
    psc_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic pkt(input logic [7:0] cmd, input logic [7:0] prm, input bit hp, input int n);
        u_host.packet(cmd, prm, hp, n);
        @(negedge clk);
    endtask
    task automatic wait_bit(input int n, input logic v, input int lim);
        cyc = 0;
        while (status[n] !== v && cyc < lim) begin
            @(negedge clk);
            cyc++;
        end
        check(status[n], v, "flag wait");
    endtask
    task automatic t_single();
        logic [55:0] flat;
        flat = {sample.supply, sample.temperature, sample.pressure};
        pkt(`PSC_CMD_START, 8'h01, 1'b1, 0);
        check(status, 8'h89, "start");
        wait_bit(4, 1'b1, 3 * FIRST_CYC);
        check(cyc > FIRST_CYC - 500 && cyc <= FIRST_CYC, 1, "first time");
        // The measuring bit falls one core cycle after the fresh sample bit rises.
        repeat (2) @(negedge clk);
        check({ready, status}, 9'h191, "done");
        pkt(`PSC_CMD_NOOP, 8'h00, 1'b0, 0);
        check({ready, status, u_host.rx_q[0]}, 17'h1_9191, "noop");
        pkt(`PSC_CMD_FETCH_SAMPLE, 8'h00, 1'b0, 8);
        for (int k = 1; k < 8; k++) begin
            check(u_host.rx_q[k + 1], flat[8 * (k - 1) +: 8], "sample");
        end
        check({ready, status}, 9'h081, "fetched");
    endtask
    task automatic t_repeat();
        logic [47:0] flat;
        flat = {baro.baro_temp, baro.cm_pressure};
        pkt(`PSC_CMD_START, 8'h07, 1'b1, 0);
        check(status, 8'h8F, "repeat start");
        wait_bit(5, 1'b1, 3 * FIRST_CYC);
        check(cyc > 2 * NEXT_CYC && cyc <= 3 * NEXT_CYC, 1, "third conversion");
        pkt(`PSC_CMD_FETCH_BARO, 8'h00, 1'b0, 6);
        for (int k = 0; k < 6; k++) begin
            check(u_host.rx_q[k + 1], flat[8 * k +: 8], "baro");
        end
        check(status[5], 1'b0, "baro flag");
        pkt(`PSC_CMD_HALT, 8'h00, 1'b0, 0);
        check(status[3], 1'b1, "halt runs on");
        wait_bit(3, 1'b0, 2 * NEXT_CYC);
        check(status[4], 1'b1, "last result");
    endtask
    task automatic t_ident();
        pkt(`PSC_CMD_FETCH_ID, 8'h00, 1'b0, 64);
        check(u_host.rx_q.size(), 65, "id length");
        check({u_host.rx_q[2], u_host.rx_q[1]}, {FW_MAJ, FW_MIN}, "firmware");
        for (int k = 31; k < 64; k++) begin
            check(u_host.rx_q[k + 1], 8'hFF, "reserved");
        end
    endtask
    task automatic t_reboot();
        pkt(`PSC_CMD_START, 8'h01, 1'b1, 0);
        pkt(`PSC_CMD_REBOOT, 8'h00, 1'b0, 0);
        check({ready, status}, 9'h083, "reboot");
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #400us;
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check({ready, status}, 9'h083, "reset");
        t_single();
        t_repeat();
        t_ident();
        t_reboot();
        give_verdict();
    end
endmodule // psc_sensor_bench
